// ---- spt_consts.vh ----
// constants of the section performance timer: register map, field
// positions, reset values and tick timing.
// assumes a 100 MHz system clock and an apb slave with 32-bit data.
`ifndef SPT_CONSTS_VH
`define SPT_CONSTS_VH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define SPT_OFS_CTRL 12'h000
`define SPT_OFS_CMD 12'h004
`define SPT_OFS_STATUS 12'h008
`define SPT_OFS_SEL 12'h00c
`define SPT_OFS_TOTAL_LO 12'h010
`define SPT_OFS_TOTAL_HI 12'h014
`define SPT_OFS_PASS 12'h018
`define SPT_OFS_MAX_LO 12'h01c
`define SPT_OFS_MAX_HI 12'h020
`define SPT_OFS_MIN_LO 12'h024
`define SPT_OFS_MIN_HI 12'h028

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define SPT_CTRL_IVL_LSB 0
`define SPT_CTRL_EN_LSB 8
`define SPT_CTRL_EVCNT_LSB 16
`define SPT_CMD_CLRALL_BIT 8
`define SPT_STAT_RUN_BIT 0
`define SPT_STAT_ACT_LSB 8
`define SPT_STAT_OVF_LSB 16

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define SPT_RST_IVL 3'h0
`define SPT_RST_EN 8'h00
`define SPT_RST_EVCNT 8'h01
`define SPT_RST_MIN 40'hff_ffff_ffff
`define SPT_MAX40 40'hff_ffff_ffff
`define SPT_MAX32 32'hffff_ffff

// ------------------------------------------------------------
// timing: clock period and tick periods in ns
// ------------------------------------------------------------
`define SPT_CLK_NS 10
`define SPT_TICK0_NS 10
`define SPT_TICK1_NS 20
`define SPT_TICK2_NS 40
`define SPT_TICK3_NS 80
`define SPT_TICK4_NS 160
`define SPT_TICK5_NS 1600
`define SPT_IVL_LAST 3'h5

`endif

// ---- spt_cpu_model.sv ----
// model of the target cpu: run level and event detector pulses.
// assumes the bench calls its tasks; events are one-cycle pulses.
`timescale 1ns/100ps
module spt_cpu_model (
    input wire sys_clk,
    output logic prog_running,
    output logic [31:0] start_evt,
    output logic [31:0] end_evt
);
    // idle: halted, no events
    initial begin
        prog_running = 1'b0;
        start_evt = 32'h0000_0000;
        end_evt = 32'h0000_0000;
    end
    // run level changes only after an edge, settings stay untouched
    task go(input logic r);
        @(posedge sys_clk);
        prog_running <= r;
    endtask
    // one-cycle pulse on any start and end sources, four per section
    task fire(input logic [31:0] s, input logic [31:0] e);
        @(posedge sys_clk);
        start_evt <= s;
        end_evt <= e;
        @(posedge sys_clk);
        start_evt <= 32'h0000_0000;
        end_evt <= 32'h0000_0000;
    endtask
endmodule

// ---- spt_perf_timer.v ----
// section performance timer: eight measured program sections with
// total, pass count, max and min time, behind an apb register slave.
// assumes start and end events are one-cycle synchronous pulses from
// the cpu event detectors, four sources per section, and that
// prog_running is high while the target program executes.
//
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/100ps
`include "spt_consts.vh"

// What this block does
// - eight sections sharing one interval setting
// - interval 10,20,40,80,160ns or 1.6us, default 10ns
// - 40-bit time counter advanced per tick
// - 32-bit pass counter up to all ones
// - keep total, max and min per section
// - measuring starts when program runs
// - results frozen and readable while halted
// - rerun adds to previous results
// - clear one section or all sections
// - disabled section never measures
// - any of several end events closes
// - duration error under two ticks
// - event counts always act as one
module spt_perf_timer (
    input wire sys_clk,
    input wire reset_n,
    input wire [11:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    output reg [31:0] prdata_ff,
    output reg pready_ff,
    output reg pslverr_ff,
    input wire prog_running,
    input wire [31:0] start_evt,
    input wire [31:0] end_evt,
    output reg [7:0] meas_active_ff
);

// ------------------------------------------------------------
// section states
// ------------------------------------------------------------
localparam [1:0] ST_IDLE = 2'h0; // waiting for a start event
localparam [1:0] ST_ARMED = 2'h1; // start seen, waiting for tick
localparam [1:0] ST_TIMING = 2'h2; // counting ticks

// ------------------------------------------------------------
// helpers
// ------------------------------------------------------------
// saturating 40-bit increment
// saturation keeps a wrapped count from reading as a short time
function [39:0] sat_inc40;
    input [39:0] v;
    input en;
    begin
        if (en && v != `SPT_MAX40) begin
            sat_inc40 = v + 40'h1;
        end else begin
            sat_inc40 = v;
        end
    end
endfunction

// saturating 32-bit increment
function [31:0] sat_inc32;
    input [31:0] v;
    input en;
    begin
        if (en && v != `SPT_MAX32) begin
            sat_inc32 = v + 32'h1;
        end else begin
            sat_inc32 = v;
        end
    end
endfunction

// ------------------------------------------------------------
// configuration and per-section storage
// ------------------------------------------------------------
reg [2:0] ivl_sel_ff; // shared interval code
reg [7:0] sec_en_ff; // per-section enable
reg [7:0] ev_cnt_ff; // event count, stored for readback only
reg [2:0] rd_sec_ff; // section shown in the data registers
reg [7:0] ovf_ff; // sticky overflow per section
reg [1:0] st_ff [0:7]; // section state
reg [39:0] cur_ff [0:7]; // ticks in the open measurement
reg [39:0] total_ff [0:7]; // accumulated ticks
reg [31:0] pass_ff [0:7]; // completed measurements
reg [39:0] max_ff [0:7]; // longest measurement
reg [39:0] min_ff [0:7]; // shortest, all ones when none yet

wire tick; // shared interval tick
integer i; // loop index of the section engines
integer j; // loop index of the event fan-in, kept apart so each has one driver

// one tick source serves every section
spt_tick_gen u_tick (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .run(prog_running),
    .ivl_sel(ivl_sel_ff),
    .tick_ff(tick)
);

// ------------------------------------------------------------
// apb decode
// ------------------------------------------------------------
wire apb_acc = psel & penable; // access phase
wire apb_done = apb_acc & pready_ff; // edge where transfer ends
wire apb_wr = apb_done & pwrite & ~pslverr_ff;
wire wr_ctrl = apb_wr & (paddr == `SPT_OFS_CTRL);
wire wr_cmd = apb_wr & (paddr == `SPT_OFS_CMD);
wire wr_sel = apb_wr & (paddr == `SPT_OFS_SEL);
wire [2:0] wr_ivl = pwdata[`SPT_CTRL_IVL_LSB +: 3];

reg [31:0] rd_data_c; // read mux result
reg addr_ok_c; // address is mapped
reg [7:0] clr_mask_c; // sections to clear this cycle
reg [7:0] start_any_c; // any start source fired
reg [7:0] end_any_c; // any end source fired
reg [7:0] timing_c; // section is in the timing state

// read mux; section data comes from the selected section
always @* begin
    addr_ok_c = 1'b1;
    case (paddr)
        `SPT_OFS_CTRL: rd_data_c = {8'h00, ev_cnt_ff, sec_en_ff, 5'h00, ivl_sel_ff};
        `SPT_OFS_CMD: rd_data_c = 32'h0000_0000; // command is write-only
        `SPT_OFS_STATUS: rd_data_c = {8'h00, ovf_ff, meas_active_ff, 7'h00, prog_running};
        `SPT_OFS_SEL: rd_data_c = {29'h0000_0000, rd_sec_ff};
        `SPT_OFS_TOTAL_LO: rd_data_c = total_ff[rd_sec_ff][31:0];
        `SPT_OFS_TOTAL_HI: rd_data_c = {24'h00_0000, total_ff[rd_sec_ff][39:32]};
        `SPT_OFS_PASS: rd_data_c = pass_ff[rd_sec_ff];
        `SPT_OFS_MAX_LO: rd_data_c = max_ff[rd_sec_ff][31:0];
        `SPT_OFS_MAX_HI: rd_data_c = {24'h00_0000, max_ff[rd_sec_ff][39:32]};
        `SPT_OFS_MIN_LO: rd_data_c = min_ff[rd_sec_ff][31:0];
        `SPT_OFS_MIN_HI: rd_data_c = {24'h00_0000, min_ff[rd_sec_ff][39:32]};
        default: begin
            rd_data_c = 32'h0000_0000;
            addr_ok_c = 1'b0; // unmapped
        end
    endcase
end

// event fan-in and clear decode
always @* begin
    // four sources per section are or-ed; the stored event count is
    // not used, so every single pulse opens or closes a section
    for (j = 0; j < 8; j = j + 1) begin
        start_any_c[j] = |start_evt[j*4 +: 4];
        end_any_c[j] = |end_evt[j*4 +: 4];
        timing_c[j] = (st_ff[j] == ST_TIMING);
    end
    // clear is decoded in the last cycle of the command write
    if (wr_cmd && pwdata[`SPT_CMD_CLRALL_BIT]) begin
        clr_mask_c = 8'hff;
    end else if (wr_cmd) begin
        clr_mask_c = pwdata[7:0];
    end else begin
        clr_mask_c = 8'h00;
    end
end

// ------------------------------------------------------------
// apb slave: one wait state, answer on the second access cycle
// ------------------------------------------------------------
always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
        pready_ff <= 1'b0;
        pslverr_ff <= 1'b0;
        prdata_ff <= 32'h0000_0000;
    end else if (apb_acc && !pready_ff) begin
        // the wait state gives the read mux a full cycle to settle
        pready_ff <= 1'b1;
        prdata_ff <= pwrite ? 32'h0000_0000 : rd_data_c;
        // control register writes are refused while the program runs
        pslverr_ff <= ~addr_ok_c | (pwrite & prog_running & (paddr == `SPT_OFS_CTRL));
    end else begin
        pready_ff <= 1'b0;
        pslverr_ff <= 1'b0;
    end
end

// ------------------------------------------------------------
// configuration registers
// ------------------------------------------------------------
always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
        ivl_sel_ff <= `SPT_RST_IVL;
        sec_en_ff <= `SPT_RST_EN;
        ev_cnt_ff <= `SPT_RST_EVCNT;
        rd_sec_ff <= 3'h0;
    end else begin
        if (wr_ctrl) begin
            // unsupported codes fall back to the default interval
            ivl_sel_ff <= (wr_ivl > `SPT_IVL_LAST) ? `SPT_RST_IVL : wr_ivl;
            sec_en_ff <= pwdata[`SPT_CTRL_EN_LSB +: 8];
            // any count is stored but every event acts as a single one
            ev_cnt_ff <= pwdata[`SPT_CTRL_EVCNT_LSB +: 8];
        end
        if (wr_sel) begin
            rd_sec_ff <= pwdata[2:0];
        end
    end
end

// ------------------------------------------------------------
// section measurement engines
// ------------------------------------------------------------
// a halt drops any open measurement; ticks already counted stay in
// the total, so total can exceed the sum of closed measurements
always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
        ovf_ff <= 8'h00;
        meas_active_ff <= 8'h00;
        for (i = 0; i < 8; i = i + 1) begin
            st_ff[i] <= ST_IDLE;
            cur_ff[i] <= 40'h0;
            total_ff[i] <= 40'h0;
            pass_ff[i] <= 32'h0;
            max_ff[i] <= 40'h0;
            min_ff[i] <= `SPT_RST_MIN;
        end
    end else begin
        for (i = 0; i < 8; i = i + 1) begin
            // status lags the state by one cycle so it stays a clean flop
            meas_active_ff[i] <= timing_c[i];
            if (clr_mask_c[i]) begin
                // clear wins over a close in the same cycle
                st_ff[i] <= ST_IDLE;
                cur_ff[i] <= 40'h0;
                total_ff[i] <= 40'h0;
                pass_ff[i] <= 32'h0;
                max_ff[i] <= 40'h0;
                min_ff[i] <= `SPT_RST_MIN;
                ovf_ff[i] <= 1'b0;
            end else if (!prog_running || !sec_en_ff[i]) begin
                // halted or disabled: hold results, no new measurement
                st_ff[i] <= ST_IDLE;
                cur_ff[i] <= 40'h0;
            end else begin
                // running: results keep accumulating across runs
                // only the timing state counts, so the tick that opens a
                // measurement adds nothing to it
                if (timing_c[i] && tick) begin
                    cur_ff[i] <= sat_inc40(cur_ff[i], 1'b1);
                    total_ff[i] <= sat_inc40(total_ff[i], 1'b1);
                    if (total_ff[i] == `SPT_MAX40) begin
                        ovf_ff[i] <= 1'b1;
                    end
                end
                case (st_ff[i])
                    ST_IDLE: begin
                        if (start_any_c[i]) begin
                            st_ff[i] <= ST_ARMED;
                        end
                    end
                    ST_ARMED: begin
                        if (end_any_c[i]) begin
                            // closed before the first tick: zero length
                            st_ff[i] <= ST_IDLE;
                            pass_ff[i] <= sat_inc32(pass_ff[i], 1'b1);
                            min_ff[i] <= 40'h0;
                            if (pass_ff[i] == `SPT_MAX32) begin
                                ovf_ff[i] <= 1'b1;
                            end
                        end else if (tick) begin
                            st_ff[i] <= ST_TIMING;
                            cur_ff[i] <= 40'h0;
                        end
                    end
                    ST_TIMING: begin
                        // start events are ignored here
                        if (end_any_c[i]) begin
                            st_ff[i] <= ST_IDLE;
                            cur_ff[i] <= 40'h0;
                            pass_ff[i] <= sat_inc32(pass_ff[i], 1'b1);
                            if (pass_ff[i] == `SPT_MAX32) begin
                                ovf_ff[i] <= 1'b1;
                            end
                            // a tick in the closing cycle still counts
                            if (sat_inc40(cur_ff[i], tick) > max_ff[i]) begin
                                max_ff[i] <= sat_inc40(cur_ff[i], tick);
                            end
                            if (sat_inc40(cur_ff[i], tick) < min_ff[i]) begin
                                min_ff[i] <= sat_inc40(cur_ff[i], tick);
                            end
                        end
                    end
                    default: begin
                        st_ff[i] <= ST_IDLE;
                    end
                endcase
            end
        end
    end
end

endmodule

// ---- spt_perf_timer_sva.sv ----
// checker for the apb slave and section status ports of the timer.
// assumes one clock domain and a master that holds its request.
`timescale 1ns/100ps
module spt_perf_timer_sva (
    input wire sys_clk,
    input wire reset_n,
    input wire [11:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    input wire [31:0] prdata_ff,
    input wire pready_ff,
    input wire pslverr_ff,
    input wire prog_running,
    input wire [31:0] start_evt,
    input wire [31:0] end_evt,
    input wire [7:0] meas_active_ff
);
    // ----------------------------------------
    // address decode helpers
    // ----------------------------------------
    wire bad_addr; // past the map or not word aligned
    wire ctrl_busy; // control write refused while running
    assign bad_addr = (paddr > 12'h028) || (paddr[1:0] != 2'h0);
    assign ctrl_busy = pwrite && (paddr == 12'h000) && prog_running;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    a_ready_one_wait: assert property (psel && !penable |=> !pready_ff ##1 pready_ff)
        else $error("ready not two cycles after setup");
    a_ready_one_cycle: assert property (pready_ff |=> !pready_ff)
        else $error("ready longer than one cycle");
    a_ready_in_access: assert property (pready_ff |-> psel && penable)
        else $error("ready outside an access phase");
    a_err_with_ready: assert property (pslverr_ff |-> pready_ff)
        else $error("error without ready");
    a_bad_addr_err: assert property (pready_ff && bad_addr |-> pslverr_ff)
        else $error("unmapped access not refused");
    a_ctrl_run_err: assert property (pready_ff && ctrl_busy |-> pslverr_ff)
        else $error("control write accepted while running");
    a_mapped_ok: assert property (pready_ff && !bad_addr && !ctrl_busy |-> !pslverr_ff)
        else $error("mapped access refused");
    a_cmd_reads_zero: assert property (pready_ff && !pwrite && paddr == 12'h004 |-> prdata_ff == 32'h0)
        else $error("command register read not zero");
    a_halt_idle: assert property (!prog_running [*3] |-> meas_active_ff == 8'h00)
        else $error("section still timing while halted");
    a_active_needs_run: assert property (meas_active_ff != 8'h00 |-> $past(prog_running, 2))
        else $error("section timing without a running program");
endmodule

// ---- spt_perf_timer_tb.sv ----
// self-checking bench of the section performance timer.
// assumes the cpu model drives the event side; bench is apb master.
`timescale 1ns/100ps
`include "spt_consts.vh"
module spt_perf_timer_tb;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    wire [31:0] prdata_ff;
    wire pready_ff;
    wire pslverr_ff;
    wire prog_running;
    wire [31:0] start_evt;
    wire [31:0] end_evt;
    wire [7:0] meas_active_ff;
    integer err_count = 0;
    integer n_tests = 0;
    integer cyc = 0;
    integer divs [0:5] = '{1, 2, 4, 8, 16, 160}; // cycles per tick
    integer k;
    integer t1;
    logic [31:0] rd;
    logic er;
    // reset rows: address, value, refused
    logic [44:0] rows [0:10] = '{
        {`SPT_OFS_CTRL, 32'h0001_0000, 1'b0}, {`SPT_OFS_CMD, 32'h0, 1'b0},
        {`SPT_OFS_STATUS, 32'h0, 1'b0}, {`SPT_OFS_SEL, 32'h0, 1'b0},
        {`SPT_OFS_TOTAL_LO, 32'h0, 1'b0}, {`SPT_OFS_TOTAL_HI, 32'h0, 1'b0},
        {`SPT_OFS_PASS, 32'h0, 1'b0}, {`SPT_OFS_MAX_LO, 32'h0, 1'b0},
        {`SPT_OFS_MIN_LO, 32'hffff_ffff, 1'b0}, {`SPT_OFS_MIN_HI, 32'hff, 1'b0},
        {12'h02c, 32'h0, 1'b1}};
    spt_perf_timer spt_perf_timer_i (.sys_clk(sys_clk), .reset_n(reset_n),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata_ff(prdata_ff), .pready_ff(pready_ff),
        .pslverr_ff(pslverr_ff), .prog_running(prog_running),
        .start_evt(start_evt), .end_evt(end_evt), .meas_active_ff(meas_active_ff));
    spt_cpu_model spt_cpu_model_i (.sys_clk(sys_clk), .prog_running(prog_running),
        .start_evt(start_evt), .end_evt(end_evt));
    // ----------------------------------------
    // clock, timeout and helpers
    // ----------------------------------------
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    // cut a hang short well past the expected run length
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_count = err_count + 1;
            test_done();
        end
    end
    task test_done;
        $display("tests %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // range compare; unknown never counts as inside
    task chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
        n_tests = n_tests + 1;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            err_count = err_count + 1;
            $display("ERROR %0t: got %h expected %h..%h", $time, got, lo, hi);
        end
    endtask
    // one apb transfer; waits for ready, the bench timeout bounds it
    task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready_ff !== 1'b1);
        rd = prdata_ff;
        er = pslverr_ff;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // one run: start events to sections 0 and 1 (only section 0 enabled), a stray restart, end after n cycles
    task meas(input integer n, input integer src);
        spt_cpu_model_i.go(1'b1);
        repeat (3) @(posedge sys_clk);
        spt_cpu_model_i.fire(32'h11 << src, 32'h0);
        repeat (n / 2 - 1) @(posedge sys_clk);
        spt_cpu_model_i.fire(32'h1 << src, 32'h0);
        chk({24'h0, meas_active_ff}, 32'h1, 32'h1);
        repeat (n / 2 - 3) @(posedge sys_clk);
        spt_cpu_model_i.fire(32'h0, 32'h11 << src);
        spt_cpu_model_i.go(1'b0);
        repeat (3) @(posedge sys_clk);
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        for (k = 0; k < 11; k = k + 1) begin
            apb(rows[k][44:33], 1'b0, 32'h0);
            chk(rd, rows[k][32:1], rows[k][32:1]);
            chk({31'h0, er}, {31'h0, rows[k][0]}, {31'h0, rows[k][0]});
        end
        // every interval code, event count three, clear all between
        for (k = 0; k < 6; k = k + 1) begin
            apb(`SPT_OFS_CTRL, 1'b1, {8'h00, 16'h0301, 5'h00, k[2:0]});
            apb(`SPT_OFS_CMD, 1'b1, 32'h100);
            apb(`SPT_OFS_SEL, 1'b1, 32'h0);
            meas(320, k % 4);
            chk({24'h0, meas_active_ff}, 32'h0, 32'h0);
            apb(`SPT_OFS_PASS, 1'b0, 32'h0);
            chk(rd, 32'h1, 32'h1);
            apb(`SPT_OFS_TOTAL_LO, 1'b0, 32'h0);
            t1 = rd;
            chk(rd, 320 / divs[k] - 1, 320 / divs[k] + 1);
            apb(`SPT_OFS_MAX_LO, 1'b0, 32'h0);
            chk(rd, t1, t1);
            apb(`SPT_OFS_MIN_LO, 1'b0, 32'h0);
            chk(rd, t1, t1);
            apb(`SPT_OFS_SEL, 1'b1, 32'h1);
            apb(`SPT_OFS_PASS, 1'b0, 32'h0);
            chk(rd, 32'h0, 32'h0);
        end
        // rerun without clear adds to the stored results
        apb(`SPT_OFS_CTRL, 1'b1, 32'h0000_0100);
        apb(`SPT_OFS_SEL, 1'b1, 32'h0);
        apb(`SPT_OFS_CMD, 1'b1, 32'h100);
        meas(40, 0);
        apb(`SPT_OFS_TOTAL_LO, 1'b0, 32'h0);
        t1 = rd;
        meas(40, 2);
        apb(`SPT_OFS_PASS, 1'b0, 32'h0);
        chk(rd, 32'h2, 32'h2);
        apb(`SPT_OFS_TOTAL_LO, 1'b0, 32'h0);
        chk(rd, t1 + 39, t1 + 41);
        apb(`SPT_OFS_TOTAL_LO, 1'b0, 32'h0);
        chk(rd, t1 + 39, t1 + 41);
        // control write while running is refused
        spt_cpu_model_i.go(1'b1);
        repeat (2) @(posedge sys_clk);
        apb(`SPT_OFS_CTRL, 1'b1, 32'h0);
        chk({31'h0, er}, 32'h1, 32'h1);
        spt_cpu_model_i.go(1'b0);
        repeat (3) @(posedge sys_clk);
        apb(`SPT_OFS_CTRL, 1'b0, 32'h0);
        chk(rd, 32'h0000_0100, 32'h0000_0100);
        // single-section clear
        apb(`SPT_OFS_CMD, 1'b1, 32'h1);
        apb(`SPT_OFS_PASS, 1'b0, 32'h0);
        chk(rd, 32'h0, 32'h0);
        apb(`SPT_OFS_MIN_LO, 1'b0, 32'h0);
        chk(rd, 32'hffff_ffff, 32'hffff_ffff);
        // unsupported interval code falls back to the default
        apb(`SPT_OFS_CTRL, 1'b1, 32'h0000_0107);
        apb(`SPT_OFS_CTRL, 1'b0, 32'h0);
        chk(rd, 32'h0000_0100, 32'h0000_0100);
        // zero-length pass at 1.6us; start with end in idle only starts
        apb(`SPT_OFS_CTRL, 1'b1, 32'h0000_0105);
        spt_cpu_model_i.go(1'b1);
        repeat (3) @(posedge sys_clk);
        spt_cpu_model_i.fire(32'h1, 32'h1);
        spt_cpu_model_i.fire(32'h0, 32'h2);
        spt_cpu_model_i.go(1'b0);
        repeat (3) @(posedge sys_clk);
        apb(`SPT_OFS_PASS, 1'b0, 32'h0);
        chk(rd, 32'h1, 32'h1);
        apb(`SPT_OFS_MIN_LO, 1'b0, 32'h0);
        chk(rd, 32'h0, 32'h0);
        apb(`SPT_OFS_MAX_LO, 1'b0, 32'h0);
        chk(rd, 32'h0, 32'h0);
        // reset in mid-run with a section armed restores the defaults
        spt_cpu_model_i.go(1'b1);
        spt_cpu_model_i.fire(32'h1, 32'h0);
        @(posedge sys_clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        chk({24'h0, meas_active_ff}, 32'h0, 32'h0);
        spt_cpu_model_i.go(1'b0);
        apb(`SPT_OFS_CTRL, 1'b0, 32'h0);
        chk(rd, 32'h0001_0000, 32'h0001_0000);
        apb(`SPT_OFS_PASS, 1'b0, 32'h0);
        chk(rd, 32'h0, 32'h0);
        test_done();
    end
endmodule
bind spt_perf_timer spt_perf_timer_sva spt_perf_timer_sva_i (.sys_clk(sys_clk),
    .reset_n(reset_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata_ff(prdata_ff),
    .pready_ff(pready_ff), .pslverr_ff(pslverr_ff), .prog_running(prog_running),
    .start_evt(start_evt), .end_evt(end_evt), .meas_active_ff(meas_active_ff));

// ---- spt_tick_gen.v ----
// shared measurement tick generator for all sections.
// assumes run is a clean synchronous level from the target cpu.
`timescale 1ns/100ps
`include "spt_consts.vh"

module spt_tick_gen (
    input wire sys_clk,
    input wire reset_n,
    input wire run,
    input wire [2:0] ivl_sel,
    output reg tick_ff
);

// ------------------------------------------------------------
// tick periods in clock cycles
// ------------------------------------------------------------
localparam [31:0] CYC0_W = `SPT_TICK0_NS / `SPT_CLK_NS;
localparam [31:0] CYC1_W = `SPT_TICK1_NS / `SPT_CLK_NS;
localparam [31:0] CYC2_W = `SPT_TICK2_NS / `SPT_CLK_NS;
localparam [31:0] CYC3_W = `SPT_TICK3_NS / `SPT_CLK_NS;
localparam [31:0] CYC4_W = `SPT_TICK4_NS / `SPT_CLK_NS;
localparam [31:0] CYC5_W = `SPT_TICK5_NS / `SPT_CLK_NS;
// every period fits in eight bits, the longest being 160 cycles
localparam [7:0] CYC0 = CYC0_W[7:0];
localparam [7:0] CYC1 = CYC1_W[7:0];
localparam [7:0] CYC2 = CYC2_W[7:0];
localparam [7:0] CYC3 = CYC3_W[7:0];
localparam [7:0] CYC4 = CYC4_W[7:0];
localparam [7:0] CYC5 = CYC5_W[7:0];

reg [7:0] cnt_ff; // cycles since last tick
reg [7:0] per_c; // selected period

// period decode
always @* begin
    case (ivl_sel)
        3'h0: per_c = CYC0;
        3'h1: per_c = CYC1;
        3'h2: per_c = CYC2;
        3'h3: per_c = CYC3;
        3'h4: per_c = CYC4;
        3'h5: per_c = CYC5;
        default: per_c = CYC0; // unused codes fall back to finest
    endcase
end

// counter restarts with each run so tick edges align to run start
always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
        cnt_ff <= 8'h00;
        tick_ff <= 1'b0;
    end else if (!run) begin
        cnt_ff <= 8'h00;
        tick_ff <= 1'b0;
    end else if (cnt_ff == per_c - 8'h01) begin
        cnt_ff <= 8'h00;
        tick_ff <= 1'b1;
    end else begin
        cnt_ff <= cnt_ff + 8'h01;
        tick_ff <= 1'b0;
    end
end

endmodule
